// >>> src/key_qualifier.sv
`timescale 1ns/10ps
module key_qualifier #(
  parameter int QUAL = panel_pkg::QUAL_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // raw keypad
  input wire logic key_down,
  input wire logic [4:0] key_code,
  // qualified keystrokes
  panel_if.src kif
);
  localparam int CW = $clog2(QUAL + 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [4:0] code;
    logic fired;
    logic stb;
  } qst_t;
  qst_t q;
  qst_t d;

  if (QUAL < 2) begin : g_bad
    $error("QUAL must be at least 2");
  end

  // ------------------------------------------------------------
  // one pulse per firm, sustained press
  // ------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.stb = 1'b0;
    if (!key_down || key_code != q.code)
    begin
      d.cnt = '0;
      d.fired = 1'b0;
      d.code = key_code;
    end
    else if (!q.fired)
    begin
      if (q.cnt == CW'(QUAL - 1))
      begin
        d.stb = 1'b1;
        d.fired = 1'b1;
      end
      else
      begin
        d.cnt = q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      q <= '0;
    else
      q <= d;
  end

  assign kif.stb = q.stb;
  assign kif.code = q.code;

  a_brief_press: assert property (@(posedge mclk) disable iff (!rst_b)
    q.stb |-> $past(key_down) && q.cnt == CW'(QUAL - 1))
    else $error("keystroke accepted without a sustained press");
endmodule : key_qualifier

// >>> src/panel_if.sv
`timescale 1ns/10ps
interface panel_if;
  logic stb;
  logic [4:0] code;
  modport src (output stb, output code);
  modport dst (input stb, input code);
endinterface : panel_if

// >>> src/panel_key_interpreter.sv
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
// Function
// - arrow keys move cursor one node, wrapping around rows and columns
// - status lamp lit when power flows through element under cursor
// - cursor blink overrides power flow indication at its node, except while supervisory blanks the nodes
// - shift selects shifted operation of dual keys, ignored on single keys
// - any key clears shift except reference, network and search keys
// - shortcut keys show registers 4010 and 4020 and their contents
// - shift plus shortcut redefines it from a holding_register_range data entry
// - shortcut assignments persist until explicitly redefined, program reload or reset
// - program reload restores the 4010 and 4020 shortcut defaults
// - supervisory key accepted only while memory protect is off
// - entering supervisory blanks displays, shows idle banner, link lamp stays
// - supervisory key, code, enter; code 4 acts on the digit
// - first enter shows confirm prompt, second enter executes
// - reference shows SUP and code while executing, data shows DONE
// - codes 0 to 5 decode exit, stop, start, erase, live, dump
// - erase only allowed after controller halted by code 1
// - reset in supervisory returns to examine at saved cursor
// - shift reset fully resets panel, cursor home row 1 column 1
// - clear loads 0000, blanks element type, enters data entry
// - clear ignored in supervisory and error modes
// - only firm, sustained presses become keystrokes
// - reset from any mode returns to examine; persisting error reappears
module panel_key_interpreter #(
  parameter int BLINK_CYC = panel_pkg::BLINK_CYC,
  parameter int QUAL = panel_pkg::QUAL_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // keypad
  input wire logic key_down,
  input wire logic [4:0] key_code,
  // register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // controller link
  input wire logic [27:0] pf_in,
  input wire logic [15:0] reg_val_in,
  input wire logic err_in,
  input wire logic link_ok_in,
  input wire logic cmd_done_in,
  input wire logic logic_reload_in,
  output logic cmd_stb,
  output logic [3:0] cmd_code,
  output logic [15:0] view_ref,
  // display fields
  output logic [15:0] disp_ref,
  output panel_pkg::rsel_t ref_sel,
  output logic [3:0] ref_code,
  output logic [15:0] disp_data,
  output panel_pkg::dsel_t data_sel,
  output logic [27:0] node_out,
  output logic [1:0] cur_row,
  output logic [2:0] cur_col,
  output logic elem_blank,
  output logic net_blank,
  output logic enter_ind,
  output logic exam_ind,
  output logic shift_ind,
  output logic lamp,
  output logic link_good
);
  localparam int BW = $clog2(BLINK_CYC);
  typedef struct packed {
    panel_pkg::mode_t mode;
    panel_pkg::sup_t sup;
    panel_pkg::rsel_t ref_sel;
    panel_pkg::dsel_t dsel;
    logic shift;
    logic [1:0] row;
    logic [2:0] col;
    logic [1:0] srow;
    logic [2:0] scol;
    logic [15:0] data;
    logic [15:0] dfield;
    logic [15:0] vref;
    logic [15:0] sa;
    logic [15:0] sb;
    logic [3:0] code;
    logic live;
    logic halted;
    logic rtime;
    logic mprot;
    logic pf_blank;
    logic net_blank;
    logic elem_blank;
    logic exam;
    logic enter;
    logic lamp;
    logic link;
    logic cmd_stb;
    logic [27:0] node;
    logic blink;
    logic [BW-1:0] bcnt;
    logic [31:0] rdata;
  } st_t;
  typedef struct packed {
    logic [15:0] rsvd;
    logic [3:0] mode;
    logic [3:0] sup;
    logic shift;
    logic halted;
    logic rtime;
    logic [1:0] row;
    logic [2:0] col;
  } stat_t;
  localparam st_t ST_RST = '{mode: panel_pkg::M_EXAM, sup: panel_pkg::S_CODE,
    ref_sel: panel_pkg::R_NUM, dsel: panel_pkg::D_NUM,
    sa: panel_pkg::REG_A_DEF, sb: panel_pkg::REG_B_DEF,
    live: 1'b1, exam: 1'b1, default: '0};

  st_t q;
  st_t d;
  logic k;
  logic [4:0] kc;
  logic shifted;
  logic is_dig;
  logic [3:0] dig;
  logic [27:0] hit;
  logic [27:0] node_nxt;
  stat_t stat;

  if (BLINK_CYC < 2) begin : g_bad
    $error("BLINK_CYC must be at least 2");
  end

  // ------------------------------------------------------------
  // keystroke qualification
  // ------------------------------------------------------------
  panel_if kif();
  key_qualifier #(.QUAL(QUAL)) u_qual (
    .mclk(mclk),
    .rst_b(rst_b),
    .key_down(key_down),
    .key_code(key_code),
    .kif(kif.src)
  );
  assign k = kif.stb;
  assign kc = kif.code;

  // ------------------------------------------------------------
  // node display, cursor node blinks
  // ------------------------------------------------------------
  for (genvar r = 0; r < panel_pkg::ROWS; r++)
  begin : g_row
    for (genvar c = 0; c < panel_pkg::COLS; c++)
    begin : g_col
      localparam int N = r * panel_pkg::COLS + c;
      assign hit[N] = (q.row == 2'(r)) && (q.col == 3'(c));
      assign node_nxt[N] = q.pf_blank ? 1'b0 : (hit[N] ? q.blink : pf_in[N]);
    end
  end

  always_comb
  begin
    stat = '{mode: q.mode, sup: q.sup, shift: q.shift, halted: q.halted,
      rtime: q.rtime, row: q.row, col: q.col, default: '0};
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.cmd_stb = 1'b0;
    d.rdata = '0;
    shifted = q.shift;
    is_dig = (kc <= panel_pkg::K_9);
    dig = kc[3:0];
    if (q.bcnt == BW'(BLINK_CYC - 1))
    begin
      d.bcnt = '0;
      d.blink = ~q.blink;
    end
    else
    begin
      d.bcnt = q.bcnt + 1'b1;
    end
    if (wr && addr == panel_pkg::A_CTRL)
      d.mprot = wdata[panel_pkg::CTRL_MPROT];
    if (rd)
    begin
      if (addr == panel_pkg::A_CTRL)
        d.rdata = 32'(q.mprot);
      else if (addr == panel_pkg::A_STAT)
        d.rdata = stat;
      else if (addr == panel_pkg::A_SHORT)
        d.rdata = {q.sb, q.sa};
      else if (addr == panel_pkg::A_FIELD)
        d.rdata = {q.vref, q.dfield};
    end
    if (logic_reload_in)
    begin
      d.sa = panel_pkg::REG_A_DEF;
      d.sb = panel_pkg::REG_B_DEF;
    end
    if (cmd_done_in && q.mode == panel_pkg::M_SUPERVISORY_KEY && q.sup == panel_pkg::S_BUSY)
    begin
      d.dsel = panel_pkg::D_DONE;
      d.sup = panel_pkg::S_CODE;
      if (q.code == panel_pkg::SUP_STOP)
        d.halted = 1'b1;
      else if (q.code == panel_pkg::SUP_START)
        d.halted = 1'b0;
    end
    if (k)
    begin
      if (kc != panel_pkg::K_REF && kc != panel_pkg::K_NET && kc != panel_pkg::K_SEARCH_KEY)
        d.shift = 1'b0;
      if (kc == panel_pkg::K_SHIFT)
        d.shift = 1'b1;
      if (kc == panel_pkg::K_RESET)
      begin
        d.mode = panel_pkg::M_EXAM;
        d.sup = panel_pkg::S_CODE;
        d.ref_sel = panel_pkg::R_NUM;
        d.dsel = panel_pkg::D_NUM;
        d.live = 1'b1;
        d.pf_blank = 1'b0;
        d.net_blank = 1'b0;
        d.elem_blank = 1'b0;
        if (shifted)
        begin
          d.row = '0;
          d.col = '0;
          d.data = '0;
          d.rtime = 1'b0;
        end
        else if (q.mode == panel_pkg::M_SUPERVISORY_KEY)
        begin
          d.row = q.srow;
          d.col = q.scol;
        end
      end
      else if (q.mode == panel_pkg::M_SUPERVISORY_KEY)
      begin
        if (is_dig && (q.sup == panel_pkg::S_CODE || q.sup == panel_pkg::S_ARMED)
            && dig <= panel_pkg::SUP_MAX)
        begin
          d.code = dig;
          d.dsel = panel_pkg::D_BLANK;
          if (dig == panel_pkg::SUP_LIVE)
          begin
            d.cmd_stb = 1'b1;
            d.rtime = 1'b1;
            d.sup = panel_pkg::S_BUSY;
          end
          else
          begin
            d.sup = panel_pkg::S_ARMED;
          end
        end
        else if (kc == panel_pkg::K_ENTER && q.sup == panel_pkg::S_ARMED)
        begin
          if (q.code == panel_pkg::SUP_EXIT)
          begin
            d.mode = panel_pkg::M_EXAM;
            d.ref_sel = panel_pkg::R_NUM;
            d.dsel = panel_pkg::D_NUM;
            d.pf_blank = 1'b0;
            d.net_blank = 1'b0;
            d.elem_blank = 1'b0;
            d.row = q.srow;
            d.col = q.scol;
          end
          else
          begin
            d.sup = panel_pkg::S_CONFIRM_PROMPT;
            d.dsel = panel_pkg::D_CONFIRM_PROMPT;
          end
        end
        else if (kc == panel_pkg::K_ENTER && q.sup == panel_pkg::S_CONFIRM_PROMPT)
        begin
          if (q.code == panel_pkg::SUP_ERASE && !q.halted)
          begin
            d.mode = panel_pkg::M_ERR;
          end
          else
          begin
            d.cmd_stb = 1'b1;
            d.sup = panel_pkg::S_BUSY;
            d.dsel = panel_pkg::D_BLANK;
          end
        end
      end
      else if (q.mode != panel_pkg::M_ERR)
      begin
        case (kc)
          panel_pkg::K_UP: d.row = q.row - 1'b1;
          panel_pkg::K_DOWN: d.row = q.row + 1'b1;
          panel_pkg::K_LEFT: d.col = (q.col == '0) ? panel_pkg::COL_LAST : q.col - 1'b1;
          panel_pkg::K_RIGHT: d.col = (q.col == panel_pkg::COL_LAST) ? '0 : q.col + 1'b1;
          panel_pkg::K_SHORT_A, panel_pkg::K_SHORT_B:
          begin
            if (shifted && q.data[15:8] != panel_pkg::HR_PREFIX)
            begin
              d.mode = panel_pkg::M_ERR;
            end
            else
            begin
              d.mode = panel_pkg::M_EXAM;
              d.live = 1'b1;
              d.dsel = panel_pkg::D_NUM;
              if (shifted)
              begin
                d.vref = q.data;
                d.elem_blank = 1'b1;
                if (kc == panel_pkg::K_SHORT_A)
                  d.sa = q.data;
                else
                  d.sb = q.data;
              end
              else
              begin
                d.vref = (kc == panel_pkg::K_SHORT_A) ? q.sa : q.sb;
              end
            end
          end
          panel_pkg::K_SUPERVISORY_KEY:
          begin
            if (!q.mprot)
            begin
              d.mode = panel_pkg::M_SUPERVISORY_KEY;
              d.sup = panel_pkg::S_CODE;
              d.code = panel_pkg::SUP_EXIT;
              d.srow = q.row;
              d.scol = q.col;
              d.ref_sel = panel_pkg::R_SUP;
              d.dsel = panel_pkg::D_BLANK;
              d.pf_blank = 1'b1;
              d.net_blank = 1'b1;
              d.elem_blank = 1'b1;
            end
          end
          panel_pkg::K_CLEAR:
          begin
            d.data = '0;
            d.live = 1'b0;
            d.dsel = panel_pkg::D_NUM;
            d.elem_blank = 1'b1;
            d.mode = panel_pkg::M_ENTRY;
          end
          panel_pkg::K_ENTER: d.mode = panel_pkg::M_EXAM;
          default:
          begin
            if (is_dig)
            begin
              d.data = {q.data[11:0], dig};
              d.live = 1'b0;
              d.dsel = panel_pkg::D_NUM;
              d.mode = panel_pkg::M_ENTRY;
            end
          end
        endcase
      end
    end
    if (err_in)
      d.mode = panel_pkg::M_ERR;
    d.dfield = d.live ? reg_val_in : d.data;
    d.exam = (d.mode == panel_pkg::M_EXAM);
    d.enter = (d.mode == panel_pkg::M_ENTRY);
    d.node = node_nxt;
    d.lamp = !q.pf_blank && |(hit & pf_in);
    d.link = link_ok_in;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      q <= ST_RST;
    else
      q <= d;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rdata = q.rdata;
  assign cmd_stb = q.cmd_stb;
  assign cmd_code = q.code;
  assign view_ref = q.vref;
  assign disp_ref = q.vref;
  assign ref_sel = q.ref_sel;
  assign ref_code = q.code;
  assign disp_data = q.dfield;
  assign data_sel = q.dsel;
  assign node_out = q.node;
  assign cur_row = q.row;
  assign cur_col = q.col;
  assign elem_blank = q.elem_blank;
  assign net_blank = q.net_blank;
  assign enter_ind = q.enter;
  assign exam_ind = q.exam;
  assign shift_ind = q.shift;
  assign lamp = q.lamp;
  assign link_good = q.link;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_cursor_wrap: assert property (@(posedge mclk) disable iff (!rst_b)
    k && kc == panel_pkg::K_RIGHT && q.col == panel_pkg::COL_LAST && !err_in
    && (q.mode == panel_pkg::M_EXAM || q.mode == panel_pkg::M_ENTRY)
    |=> q.col == '0 && $stable(q.row))
    else $error("cursor did not wrap to column one");
  a_blink_wins: assert property (@(posedge mclk) disable iff (!rst_b)
    !$past(q.pf_blank) |-> |(q.node & $past(hit)) == $past(q.blink))
    else $error("cursor node not showing blink phase");
  a_shift_held: assert property (@(posedge mclk) disable iff (!rst_b)
    k && q.shift && (kc == panel_pkg::K_NET || kc == panel_pkg::K_SEARCH_KEY) |=> q.shift)
    else $error("shift dropped by network or search key");
  a_reload_dflt: assert property (@(posedge mclk) disable iff (!rst_b)
    logic_reload_in && !k |=> q.sa == panel_pkg::REG_A_DEF && q.sb == panel_pkg::REG_B_DEF)
    else $error("shortcut defaults not restored");
  a_protect_block: assert property (@(posedge mclk) disable iff (!rst_b)
    k && kc == panel_pkg::K_SUPERVISORY_KEY && q.mprot && q.mode != panel_pkg::M_SUPERVISORY_KEY
    |=> q.mode != panel_pkg::M_SUPERVISORY_KEY)
    else $error("supervisory entered under memory protect");
  a_code4_now: assert property (@(posedge mclk) disable iff (!rst_b)
    k && q.mode == panel_pkg::M_SUPERVISORY_KEY && q.sup == panel_pkg::S_CODE && !err_in
    && kc == 5'(panel_pkg::SUP_LIVE) |=> cmd_stb && cmd_code == panel_pkg::SUP_LIVE)
    else $error("live display code did not issue at once");
  a_confirm_prompt_prompt: assert property (@(posedge mclk) disable iff (!rst_b)
    k && kc == panel_pkg::K_ENTER && q.mode == panel_pkg::M_SUPERVISORY_KEY && !err_in
    && q.sup == panel_pkg::S_ARMED && q.code != panel_pkg::SUP_EXIT
    |=> data_sel == panel_pkg::D_CONFIRM_PROMPT && !cmd_stb ##1 !cmd_stb)
    else $error("first enter did not show confirm prompt");
  a_erase_halted: assert property (@(posedge mclk) disable iff (!rst_b)
    cmd_stb && cmd_code == panel_pkg::SUP_ERASE |-> q.halted)
    else $error("erase issued while controller scanning");
  a_clear_ignored: assert property (@(posedge mclk) disable iff (!rst_b)
    k && kc == panel_pkg::K_CLEAR && q.mode == panel_pkg::M_SUPERVISORY_KEY && !err_in
    |=> q.mode == panel_pkg::M_SUPERVISORY_KEY && $stable(q.data))
    else $error("clear acted in supervisory mode");
  a_bad_code: assert property (@(posedge mclk) disable iff (!rst_b)
    k && q.mode == panel_pkg::M_SUPERVISORY_KEY && kc > 5'(panel_pkg::SUP_MAX) && kc <= panel_pkg::K_9
    && !cmd_done_in
    |=> !cmd_stb && $stable(q.code) && $stable(q.sup))
    else $error("invalid supervisory code accepted");
endmodule : panel_key_interpreter

// >>> src/panel_pkg.sv
package panel_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int QUAL_US = 10;
  localparam int QUAL_CYC = QUAL_US * CLK_MHZ;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
  // ------------------------------------------------------------
  // geometry and key codes
  // ------------------------------------------------------------
  localparam int ROWS = 4;
  localparam int COLS = 7;
  localparam int NODES = ROWS * COLS;
  localparam logic [1:0] ROW_LAST = 2'h3;
  localparam logic [2:0] COL_LAST = 3'h6;
  localparam logic [4:0] K_9 = 5'h09;
  localparam logic [4:0] K_UP = 5'h0a;
  localparam logic [4:0] K_DOWN = 5'h0b;
  localparam logic [4:0] K_LEFT = 5'h0c;
  localparam logic [4:0] K_RIGHT = 5'h0d;
  localparam logic [4:0] K_SHIFT = 5'h0e;
  localparam logic [4:0] K_SHORT_A = 5'h0f;
  localparam logic [4:0] K_SHORT_B = 5'h10;
  localparam logic [4:0] K_SUPERVISORY_KEY = 5'h11;
  localparam logic [4:0] K_ENTER = 5'h12;
  localparam logic [4:0] K_RESET = 5'h13;
  localparam logic [4:0] K_CLEAR = 5'h14;
  localparam logic [4:0] K_REF = 5'h15;
  localparam logic [4:0] K_NET = 5'h16;
  localparam logic [4:0] K_SEARCH_KEY = 5'h17;
  // ------------------------------------------------------------
  // registers, codes, reset values
  // ------------------------------------------------------------
  localparam logic [15:0] REG_A_DEF = 16'h4010;
  localparam logic [15:0] REG_B_DEF = 16'h4020;
  localparam logic [7:0] HR_PREFIX = 8'h40;
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_STAT = 4'h4;
  localparam logic [3:0] A_SHORT = 4'h8;
  localparam logic [3:0] A_FIELD = 4'hc;
  localparam int CTRL_MPROT = 0;
  localparam logic [3:0] SUP_EXIT = 4'h0;
  localparam logic [3:0] SUP_STOP = 4'h1;
  localparam logic [3:0] SUP_START = 4'h2;
  localparam logic [3:0] SUP_ERASE = 4'h3;
  localparam logic [3:0] SUP_LIVE = 4'h4;
  localparam logic [3:0] SUP_MAX = 4'h5;
  typedef enum logic [3:0] {M_EXAM = 4'b0001, M_ENTRY = 4'b0010,
    M_SUPERVISORY_KEY = 4'b0100, M_ERR = 4'b1000} mode_t;
  typedef enum logic [3:0] {S_CODE = 4'b0001, S_ARMED = 4'b0010,
    S_CONFIRM_PROMPT = 4'b0100, S_BUSY = 4'b1000} sup_t;
  typedef enum logic [3:0] {D_NUM = 4'b0001, D_BLANK = 4'b0010,
    D_CONFIRM_PROMPT = 4'b0100, D_DONE = 4'b1000} dsel_t;
  typedef enum logic [1:0] {R_NUM = 2'b01, R_SUP = 2'b10} rsel_t;
endpackage : panel_pkg

// >>> tb/ctrl_model.sv
`timescale 1ns/10ps
module ctrl_model #(
  parameter int DLY = 6
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // commands from the panel
  input wire logic cmd_stb,
  input wire logic [3:0] cmd_code,
  input wire logic [15:0] view_ref,
  // answers to the panel
  output logic [15:0] reg_val_in,
  output logic cmd_done_in,
  output logic scan_q,
  output logic bad_q
);
  int cnt;
  // ----------------------------------------------------------
  // register contents seen by the panel
  // ----------------------------------------------------------
  assign reg_val_in = {view_ref[7:0], 8'h5a};
  // ----------------------------------------------------------
  // command execution, done pulse after a delay
  // ----------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    cmd_done_in <= 1'b0;
    if (!rst_b)
    begin
      cnt <= 0;
      scan_q <= 1'b1;
      bad_q <= 1'b0;
    end
    else if (cmd_stb)
    begin
      cnt <= DLY;
      if (cmd_code == panel_pkg::SUP_STOP)
        scan_q <= 1'b0;
      if (cmd_code == panel_pkg::SUP_START)
        scan_q <= 1'b1;
      if (cmd_code == panel_pkg::SUP_ERASE && scan_q)
        bad_q <= 1'b1;
    end
    else if (cnt == 1)
    begin
      cmd_done_in <= 1'b1;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule : ctrl_model

// >>> tb/tb_handheld_panel_key_interpreter.sv
`timescale 1ns/10ps
module tb_handheld_panel_key_interpreter;
  localparam int QUAL = 4;
  logic mclk, rst_b, key_down, wr, rd, err_in, link_ok_in, logic_reload_in;
  logic cmd_done_in, cmd_stb, elem_blank, net_blank, enter_ind, exam_ind;
  logic shift_ind, lamp, link_good, scan_q, bad_q, s0, s1;
  logic [4:0] key_code;
  logic [3:0] addr, cmd_code, ref_code, last_code;
  logic [31:0] wdata, rdata, v;
  logic [27:0] pf_in, node_out;
  logic [15:0] reg_val_in, view_ref, disp_ref, disp_data;
  logic [1:0] cur_row;
  logic [2:0] cur_col;
  panel_pkg::rsel_t ref_sel;
  panel_pkg::dsel_t data_sel;
  int fail_count = 0;
  int cmp_count = 0;
  int stb_n = 0;
  panel_key_interpreter #(.BLINK_CYC(8), .QUAL(QUAL)) dut_u (.mclk, .rst_b, .key_down,
    .key_code, .addr, .wdata, .wr, .rd, .rdata, .pf_in, .reg_val_in, .err_in,
    .link_ok_in, .cmd_done_in, .logic_reload_in, .cmd_stb, .cmd_code, .view_ref,
    .disp_ref, .ref_sel, .ref_code, .disp_data, .data_sel, .node_out, .cur_row,
    .cur_col, .elem_blank, .net_blank, .enter_ind, .exam_ind, .shift_ind, .lamp,
    .link_good);
  ctrl_model ctrl_u (.mclk, .rst_b, .cmd_stb, .cmd_code, .view_ref, .reg_val_in,
    .cmd_done_in, .scan_q, .bad_q);
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  always @(posedge mclk)
    if (cmd_stb === 1'b1)
    begin
      stb_n++;
      last_code = cmd_code;
    end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic key(input logic [4:0] c, input int n = QUAL + 3);
    @(posedge mclk);
    key_down <= 1'b1;
    key_code <= c;
    repeat (n) @(posedge mclk);
    key_down <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
  endtask : key
  task automatic rreg(input logic [3:0] a);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg
  task automatic end_sim;
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_regs;
    chk(exam_ind, 1'b1);
    rreg(4'h8);
    chk(v, 32'h40204010);
    wreg(4'h8, 32'h0);
    rreg(4'h2);
    chk(v, 32'h0);
    rreg(4'h8);
    chk(v, 32'h40204010);
  endtask : t_regs
  task automatic t_cursor;
    @(posedge mclk) pf_in <= 28'h0000042;
    key(panel_pkg::K_LEFT, 2);
    chk(cur_col, 3'h0);
    chk(lamp, 1'b0);
    key(panel_pkg::K_LEFT);
    chk({cur_row, cur_col}, {2'h0, 3'h6});
    chk(lamp, 1'b1);
    {s0, s1} = 2'b00;
    repeat (20)
    begin
      @(posedge mclk) #1;
      s0 |= !node_out[6];
      s1 |= node_out[6];
    end
    chk({s0, s1, node_out[1]}, 3'h7);
    key(panel_pkg::K_RIGHT);
    chk(cur_col, 3'h0);
    key(panel_pkg::K_SHIFT);
    key(panel_pkg::K_NET);
    chk(shift_ind, 1'b1);
    key(panel_pkg::K_UP);
    chk({shift_ind, cur_row}, {1'b0, 2'h3});
    key(panel_pkg::K_DOWN);
    chk(cur_row, 2'h0);
  endtask : t_cursor
  task automatic t_short;
    key(panel_pkg::K_SHORT_B);
    chk({disp_ref, disp_data}, 32'h4020205a);
    key(5'h04);
    key(5'h00);
    key(5'h03);
    key(5'h02);
    key(panel_pkg::K_SHIFT);
    key(panel_pkg::K_SHORT_A);
    chk({disp_ref, disp_data}, 32'h4032325a);
    chk(elem_blank, 1'b1);
    rreg(4'h8);
    chk(v, 32'h40204032);
    @(posedge mclk) logic_reload_in <= 1'b1;
    @(posedge mclk) logic_reload_in <= 1'b0;
    rreg(4'h8);
    chk(v, 32'h40204010);
    key(panel_pkg::K_CLEAR);
    chk({disp_data, elem_blank}, 17'h00001);
    rreg(4'h4);
    chk(v[15:12], panel_pkg::M_ENTRY);
  endtask : t_short
  task automatic run_cmd(input logic [3:0] c);
    int n;
    n = stb_n;
    key(panel_pkg::K_SUPERVISORY_KEY);
    key({1'b0, c});
    key(panel_pkg::K_ENTER);
    chk({data_sel, 28'(stb_n)}, {panel_pkg::D_CONFIRM_PROMPT, 28'(n)});
    key(panel_pkg::K_ENTER);
    chk({last_code, 28'(stb_n)}, {c, 28'(n + 1)});
    for (int i = 0; i < 40 && data_sel !== panel_pkg::D_DONE; i++)
      @(posedge mclk);
    #1;
    chk({data_sel, ref_sel, ref_code}, {panel_pkg::D_DONE, panel_pkg::R_SUP, c});
    key(panel_pkg::K_RESET);
  endtask : run_cmd
  task automatic t_supervisory_key;
    wreg(4'h0, 32'h1);
    key(panel_pkg::K_SUPERVISORY_KEY);
    chk(ref_sel, panel_pkg::R_NUM);
    wreg(4'h0, 32'h0);
    key(panel_pkg::K_RIGHT);
    key(panel_pkg::K_RIGHT);
    key(panel_pkg::K_SUPERVISORY_KEY);
    chk({ref_sel, ref_code, data_sel}, {panel_pkg::R_SUP, 4'h0, panel_pkg::D_BLANK});
    chk({net_blank, elem_blank, lamp, exam_ind, enter_ind, link_good}, 6'h31);
    chk(node_out, 28'h0);
    key(panel_pkg::K_CLEAR);
    chk(data_sel, panel_pkg::D_BLANK);
    key(panel_pkg::K_9);
    chk({ref_code, 28'(stb_n)}, 32'h0);
    key(panel_pkg::K_RESET);
    rreg(4'h4);
    chk({v[15:12], cur_col}, {panel_pkg::M_EXAM, 3'h2});
    run_cmd(panel_pkg::SUP_STOP);
    chk(scan_q, 1'b0);
    run_cmd(panel_pkg::SUP_ERASE);
    run_cmd(panel_pkg::SUP_START);
    run_cmd(panel_pkg::SUP_MAX);
    chk({scan_q, bad_q}, 2'b10);
    key(panel_pkg::K_SUPERVISORY_KEY);
    key(5'h03);
    key(panel_pkg::K_ENTER);
    key(panel_pkg::K_ENTER);
    rreg(4'h4);
    chk({v[15:12], 28'(stb_n)}, {panel_pkg::M_ERR, 28'h4});
    key(panel_pkg::K_RESET);
    key(panel_pkg::K_SUPERVISORY_KEY);
    key(5'h04);
    chk({last_code, 28'(stb_n)}, {panel_pkg::SUP_LIVE, 28'h5});
    key(panel_pkg::K_RESET);
    key(panel_pkg::K_SUPERVISORY_KEY);
    key(5'h00);
    key(panel_pkg::K_ENTER);
    rreg(4'h4);
    chk(v[15:12], panel_pkg::M_EXAM);
    key(panel_pkg::K_SUPERVISORY_KEY);
    key(panel_pkg::K_SHIFT);
    key(panel_pkg::K_RESET);
    rreg(4'h4);
    chk({v[15:12], cur_col}, {panel_pkg::M_EXAM, 3'h0});
  endtask : t_supervisory_key
  task automatic t_err;
    @(posedge mclk) err_in <= 1'b1;
    @(posedge mclk) err_in <= 1'b0;
    key(panel_pkg::K_CLEAR);
    rreg(4'h4);
    chk(v[15:12], panel_pkg::M_ERR);
    key(panel_pkg::K_RESET);
    rreg(4'h4);
    chk(v[15:12], panel_pkg::M_EXAM);
  endtask : t_err
  // ----------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial
  begin
    {rst_b, key_down, wr, rd, err_in, logic_reload_in} = 6'h0;
    {key_code, addr, wdata, pf_in} = '0;
    link_ok_in = 1'b1;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_cursor();
    t_short();
    t_supervisory_key();
    t_err();
    end_sim();
  end
  initial
  begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    end_sim();
  end
endmodule : tb_handheld_panel_key_interpreter
